// [design/ssc_startup.sv]
`timescale 1ns/1ps
// Startup strap capture, power-up reset and buffered control registers
module ssc_startup (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic supply_ok_i,
	input wire logic [7:0] multifunction_pins_i,
	output logic [7:0] multifunction_pins_o,
	output logic [7:0] multifunction_pins_oe_o,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic ee_wr_i,
	input wire logic [15:0] ee_addr_i,
	input wire logic [7:0] ee_wdata_i,
	input wire logic ee_done_i,
	output logic [7:0] strap_word_o,
	output logic spi_mode_o,
	output logic [2:0] i2c_addr_low_o,
	output logic ee_start_o,
	output logic [4:0] ee_cond_o,
	output logic dev_reset_o,
	output logic cal_system_clock_input_o,
	output logic dist_sync_o,
	output logic wdog_en_o,
	output logic [7:0] loop_ctl_o,
	output logic [15:0] system_clock_input_cfg_o,
	input wire logic [7:0] irq_events_i,
	output logic irq_pin_o,
	output logic irq_pin_oe_o
);
	localparam int DW = ssc_pkg::DATA_W;
	localparam int N = ssc_pkg::NREG;

	logic supply_q;
	logic [1:0] por_cnt_q;
	logic por_active;
	logic rst_now;
	logic rst_prev_q;
	logic release_q;
	logic [7:0] strap_q;
	logic [N-1:0] hit;
	logic [ssc_pkg::IDX_W-1:0] wr_idx;
	logic [ssc_pkg::IDX_W-1:0] rd_idx;
	logic any_hit;
	logic [N*DW-1:0] shadow_all;
	logic [DW-1:0] shadow_rd;
	logic [DW-1:0] active_q [N];
	logic apply;
	logic host_wr;
	logic wr_en;
	logic [15:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_sel_q;
	logic rd_strap_q;
	logic sync_prev_q;
	logic [7:0] rdata_mux;
	logic irq_req;

	// Power-up pulse from supply rising, counted down independent of the reset pin
	always_ff @(posedge mclk_i) begin
		if (supply_ok_i && !supply_q) begin
			por_cnt_q <= ssc_pkg::POR_CNT_LOAD;
		end else if (por_cnt_q != 2'h0) begin
			por_cnt_q <= por_cnt_q - 2'h1;
		end else if (srst_i) begin
			por_cnt_q <= 2'h0;
		end
	end

	// Supply level history, kept apart from the reset pin so a pin reset never retriggers it
	always_ff @(posedge mclk_i) begin
		supply_q <= supply_ok_i;
	end

	assign por_active = (por_cnt_q != 2'h0);
	assign rst_now = srst_i | por_active;
	assign dev_reset_o = rst_now;

	// Reset release detection
	always_ff @(posedge mclk_i) begin
		rst_prev_q <= rst_now;
		release_q <= rst_prev_q & ~rst_now;
	end

	// Strap latch: transparent during reset, closed at release
	always_ff @(posedge mclk_i) begin
		if (rst_now) begin
			strap_q <= multifunction_pins_i;
		end
	end

	assign strap_word_o = strap_q;
	assign spi_mode_o = (strap_q[ssc_pkg::PROTO_LSB +: ssc_pkg::PROTO_W] == 3'h0);
	assign i2c_addr_low_o = strap_q[ssc_pkg::PROTO_LSB +: ssc_pkg::PROTO_W];
	assign ee_cond_o = strap_q[ssc_pkg::LOAD_LSB +: ssc_pkg::LOAD_W];

	// Download request two cycles after release when the load field is nonzero
	always_ff @(posedge mclk_i) begin
		if (rst_now) begin
			ee_start_o <= 1'b0;
		end else begin
			ee_start_o <= release_q && (ee_cond_o != 5'h00);
		end
	end

	// Write source: loader during download, host otherwise
	assign host_wr = reg_wr_i & ~ee_wr_i;
	assign wr_en = ee_wr_i | reg_wr_i;
	assign wr_addr = ee_wr_i ? ee_addr_i : reg_addr_i;
	assign wr_data = ee_wr_i ? ee_wdata_i : reg_wdata_i;

	// Address decode per buffered register
	for (genvar i = 0; i < N; i++) begin : g_dec
		assign hit[i] = (wr_addr == ssc_pkg::REG_ADDR[i]);
	end

	// Encode write and read indices
	always_comb begin
		wr_idx = '1;
		rd_idx = '1;
		for (int k = 0; k < N; k++) begin
			if (hit[k]) begin
				wr_idx = ssc_pkg::IDX_W'(k);
			end
			if (reg_addr_i == ssc_pkg::REG_ADDR[k]) begin
				rd_idx = ssc_pkg::IDX_W'(k);
			end
		end
	end

	assign any_hit = |hit;

	// Update strobe from host write or loader completion
	assign apply = (host_wr && reg_addr_i == ssc_pkg::ADDR_UPDATE
		&& reg_wdata_i[ssc_pkg::UPDATE_BIT]) || ee_done_i;

	ssc_shadow_mem u_shadow (
		.mclk_i(mclk_i),
		.clr_i(rst_now),
		.wr_en_i(wr_en && any_hit),
		.wr_idx_i(wr_idx),
		.wr_data_i(wr_data),
		.rd_idx_i(rd_idx),
		.rd_data_o(shadow_rd),
		.all_o(shadow_all)
	);

	// Active copies: defaults on reset, all loaded together on update
	for (genvar i = 0; i < N; i++) begin : g_act
		always_ff @(posedge mclk_i) begin
			if (rst_now) begin
				active_q[i] <= ssc_pkg::REG_RST[i];
			end else if (apply) begin
				active_q[i] <= shadow_all[i*DW +: DW];
			end
		end
	end

	// Read source tracking
	always_ff @(posedge mclk_i) begin
		if (rst_now) begin
			rd_sel_q <= 1'b0;
			rd_strap_q <= 1'b0;
		end else begin
			rd_sel_q <= reg_rd_i && rd_idx != '1;
			rd_strap_q <= reg_rd_i && reg_addr_i == ssc_pkg::ADDR_STRAP_RD;
		end
	end

	// Read data: shadow value, strap word, or zero for unmapped
	always_comb begin
		if (rd_sel_q) begin
			rdata_mux = shadow_rd;
		end else if (rd_strap_q) begin
			rdata_mux = strap_q;
		end else begin
			rdata_mux = 8'h00;
		end
	end
	assign reg_rdata_o = rdata_mux;

	// Multifunction pins undriven during any reset, else per direction register
	assign multifunction_pins_oe_o = rst_now ? 8'h00 : active_q[ssc_pkg::IX_PIN_DIR];
	assign multifunction_pins_o = active_q[ssc_pkg::IX_PIN_OUT];

	// Calibrate level and sync pulse on the active bit rising
	assign cal_system_clock_input_o = active_q[ssc_pkg::IX_SYNC_CAL][ssc_pkg::CAL_BIT];
	always_ff @(posedge mclk_i) begin
		if (rst_now) begin
			sync_prev_q <= 1'b0;
			dist_sync_o <= 1'b0;
		end else begin
			sync_prev_q <= active_q[ssc_pkg::IX_SYNC_CAL][ssc_pkg::SYNC_BIT];
			dist_sync_o <= active_q[ssc_pkg::IX_SYNC_CAL][ssc_pkg::SYNC_BIT] & ~sync_prev_q;
		end
	end

	assign wdog_en_o = active_q[ssc_pkg::IX_WDOG][ssc_pkg::WDOG_EN_BIT];
	assign loop_ctl_o = active_q[7];
	assign system_clock_input_cfg_o = {active_q[1], active_q[0]};

	// Interrupt pin: masked request, open-drain unless push-pull chosen
	assign irq_req = |(irq_events_i & active_q[ssc_pkg::IX_IRQ_MASK]);
	assign irq_pin_o = active_q[ssc_pkg::IX_IRQ_MODE][ssc_pkg::IRQ_PUSHPULL_BIT] ? ~irq_req : 1'b0;
	assign irq_pin_oe_o = active_q[ssc_pkg::IX_IRQ_MODE][ssc_pkg::IRQ_PUSHPULL_BIT]
		| irq_req;

	// Checks
	a_por_len: assert property (@(posedge mclk_i) (supply_ok_i && !supply_q && !por_active)
		|=> por_active [*2] ##1 !por_active) else $error("power-up pulse length wrong");
	a_por_alone: assert property (@(posedge mclk_i) por_active |-> dev_reset_o)
		else $error("power-up pulse did not reset");
	a_pins_hiz: assert property (@(posedge mclk_i) dev_reset_o |-> multifunction_pins_oe_o == 8'h00)
		else $error("pins driven during reset");
	a_strap_cap: assert property (@(posedge mclk_i) (dev_reset_o && !srst_i)
		|=> strap_word_o == $past(multifunction_pins_i)) else $error("strap not latched");
	a_strap_hold: assert property (@(posedge mclk_i) disable iff (dev_reset_o)
		!$past(dev_reset_o) |-> $stable(strap_word_o)) else $error("strap changed");
	a_proto_sel: assert property (@(posedge mclk_i) spi_mode_o == (strap_word_o[2:0] == 3'h0)
		&& i2c_addr_low_o == strap_word_o[2:0]) else $error("protocol select wrong");
	a_load_go: assert property (@(posedge mclk_i) disable iff (srst_i)
		($fell(dev_reset_o) && strap_word_o[7:3] != 5'h00) |-> ##2 ee_start_o)
		else $error("download not started");
	a_load_skip: assert property (@(posedge mclk_i) ee_start_o |-> ee_cond_o != 5'h00)
		else $error("download with zero condition");
	a_irq_mask: assert property (@(posedge mclk_i) disable iff (srst_i)
		$fell(dev_reset_o) |-> !irq_pin_oe_o && !wdog_en_o)
		else $error("irq or watchdog active after reset");
	a_upd_only: assert property (@(posedge mclk_i) disable iff (dev_reset_o)
		(!apply && !$past(dev_reset_o)) |=> $stable(wdog_en_o) && $stable(cal_system_clock_input_o))
		else $error("setting changed without update");
endmodule : ssc_startup

// [design/ssc_pkg.sv]
package ssc_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_PS = 40000;
	localparam int POR_PULSE_NS = 75;
	localparam int POR_CYC = (POR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HIZ_MAX_NS = 45;
	localparam int HIZ_CYC_RAW = (HIZ_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int HIZ_CYC = (HIZ_CYC_RAW < 1) ? 1 : HIZ_CYC_RAW;
	localparam logic [1:0] POR_CNT_LOAD = 2'(POR_CYC);

	// Register widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NREG = 9;
	localparam int IDX_W = 4;

	// Register offsets
	localparam logic [15:0] ADDR_UPDATE = 16'h0005;
	localparam logic [15:0] ADDR_SYSTEM_CLOCK_INPUT_CTL = 16'h0100;
	localparam logic [15:0] ADDR_SYSTEM_CLOCK_INPUT_PERIOD = 16'h0101;
	localparam logic [15:0] ADDR_PIN_DIR = 16'h0200;
	localparam logic [15:0] ADDR_PIN_OUT = 16'h0201;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'h0202;
	localparam logic [15:0] ADDR_IRQ_MODE = 16'h0203;
	localparam logic [15:0] ADDR_WDOG_CTL = 16'h0204;
	localparam logic [15:0] ADDR_LOOP_CTL = 16'h0300;
	localparam logic [15:0] ADDR_SYNC_CAL = 16'h0A02;
	localparam logic [15:0] ADDR_STRAP_RD = 16'h0D01;

	// Buffered register table, index order
	localparam logic [15:0] REG_ADDR [NREG] = '{
		ADDR_SYSTEM_CLOCK_INPUT_CTL, ADDR_SYSTEM_CLOCK_INPUT_PERIOD, ADDR_PIN_DIR, ADDR_PIN_OUT, ADDR_IRQ_MASK,
		ADDR_IRQ_MODE, ADDR_WDOG_CTL, ADDR_LOOP_CTL, ADDR_SYNC_CAL};
	localparam logic [7:0] REG_RST [NREG] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam int IX_PIN_DIR = 2;
	localparam int IX_PIN_OUT = 3;
	localparam int IX_IRQ_MASK = 4;
	localparam int IX_IRQ_MODE = 5;
	localparam int IX_WDOG = 6;
	localparam int IX_SYNC_CAL = 8;

	// Field positions
	localparam int UPDATE_BIT = 0;
	localparam int CAL_BIT = 0;
	localparam int SYNC_BIT = 1;
	localparam int WDOG_EN_BIT = 0;
	localparam int IRQ_PUSHPULL_BIT = 0;
	localparam int PROTO_LSB = 0;
	localparam int PROTO_W = 3;
	localparam int LOAD_LSB = 3;
	localparam int LOAD_W = 5;
endpackage : ssc_pkg

// [design/ssc_shadow_mem.sv]
`timescale 1ns/1ps
// Shadow register store with registered read data and a flat copy for the update transfer
module ssc_shadow_mem (
	input wire logic mclk_i,
	input wire logic clr_i,
	input wire logic wr_en_i,
	input wire logic [ssc_pkg::IDX_W-1:0] wr_idx_i,
	input wire logic [ssc_pkg::DATA_W-1:0] wr_data_i,
	input wire logic [ssc_pkg::IDX_W-1:0] rd_idx_i,
	output logic [ssc_pkg::DATA_W-1:0] rd_data_o,
	output logic [ssc_pkg::NREG*ssc_pkg::DATA_W-1:0] all_o
);
	logic [ssc_pkg::DATA_W-1:0] mem_q [ssc_pkg::NREG];

	// Per-entry storage, defaults on reset
	for (genvar i = 0; i < ssc_pkg::NREG; i++) begin : g_ent
		always_ff @(posedge mclk_i) begin
			if (clr_i) begin
				mem_q[i] <= ssc_pkg::REG_RST[i];
			end else if (wr_en_i && wr_idx_i == ssc_pkg::IDX_W'(i)) begin
				mem_q[i] <= wr_data_i;
			end
		end
		assign all_o[i*ssc_pkg::DATA_W +: ssc_pkg::DATA_W] = mem_q[i];
	end

	// Registered read port
	always_ff @(posedge mclk_i) begin
		if (clr_i) begin
			rd_data_o <= '0;
		end else if (rd_idx_i < ssc_pkg::IDX_W'(ssc_pkg::NREG)) begin
			rd_data_o <= mem_q[rd_idx_i];
		end else begin
			rd_data_o <= '0;
		end
	end
endmodule : ssc_shadow_mem

// [verification/ssc_strap_model.sv]
`timescale 1ns/1ps
// Board strap resistors on the multifunction pins
module ssc_strap_model (
	input wire logic [7:0] strap_i,
	input wire logic [7:0] drv_i,
	input wire logic [7:0] oe_i,
	output logic [7:0] pins_o
);
	// A driven pin follows the block, a released pin falls to its resistor level
	assign pins_o = (oe_i & drv_i) | (~oe_i & strap_i);
endmodule : ssc_strap_model

// [verification/ssc_startup_tb.sv]
`timescale 1ns/1ps
// Register and strap sequences with expected values
module ssc_startup_tb;
	localparam logic [7:0] PAT [5] = '{8'h00, 8'h09, 8'hF8, 8'h07, 8'h81};
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic sup = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ee_done = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] irq_ev = 8'h00;
	logic [7:0] strap = 8'h00;
	logic [7:0] pins, pins_o, pins_oe, rdata, sw, loop_ctl;
	logic spi, ee_start, dev_reset, cal, sync, wdog, irq_pin, irq_oe;
	logic [2:0] i2c_lo;
	logic [4:0] ee_cond;
	logic [15:0] system_clock_input_cfg;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int syncs = 0;
	int n;

	ssc_startup u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .supply_ok_i(sup),
		.multifunction_pins_i(pins), .multifunction_pins_o(pins_o),
		.multifunction_pins_oe_o(pins_oe), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ee_wr_i(1'b0),
		.ee_addr_i(16'h0000), .ee_wdata_i(8'h00), .ee_done_i(ee_done), .strap_word_o(sw),
		.spi_mode_o(spi), .i2c_addr_low_o(i2c_lo), .ee_start_o(ee_start),
		.ee_cond_o(ee_cond), .dev_reset_o(dev_reset), .cal_system_clock_input_o(cal),
		.dist_sync_o(sync), .wdog_en_o(wdog), .loop_ctl_o(loop_ctl),
		.system_clock_input_cfg_o(system_clock_input_cfg), .irq_events_i(irq_ev), .irq_pin_o(irq_pin),
		.irq_pin_oe_o(irq_oe));
	ssc_strap_model u_straps (.strap_i(strap), .drv_i(pins_o), .oe_i(pins_oe), .pins_o(pins));

	// Clock, sync pulse count and hang limit
	always #20 mclk_i = ~mclk_i;
	always @(negedge mclk_i) begin
		if (sync === 1'b1) syncs++;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask : tick
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		addr = a;
		wdata = d;
		tick(1);
		reg_wr = 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		reg_rd = 1'b1;
		addr = a;
		tick(1);
		reg_rd = 1'b0;
		chk("rdata", {8'h00, exp}, {8'h00, rdata});
		tick(1);
	endtask : rd
	// Pin reset with a strap pattern, then count download requests
	task automatic rst(input logic [7:0] v);
		strap = v;
		srst_i = 1'b1;
		tick(2);
		chk("reset_oe", 16'h0000, {8'h00, pins_oe});
		chk("dev_reset", 16'h0001, {15'h0000, dev_reset});
		srst_i = 1'b0;
		tick(1);
		chk("pin_release", 16'h0000, {15'h0000, dev_reset});
		n = 0;
		repeat (5) begin
			tick(1);
			if (ee_start === 1'b1) n++;
		end
		chk("strap", {8'h00, v}, {8'h00, sw});
		chk("spi", {15'h0000, v[2:0] == 3'h0}, {15'h0000, spi});
		chk("i2c_lo", {13'h0000, v[2:0]}, {13'h0000, i2c_lo});
		chk("ee_cond", {11'h000, v[7:3]}, {11'h000, ee_cond});
		chk("ee_start", 16'((v[7:3] != 5'h00) ? 1 : 0), 16'(n));
	endtask : rst
	// Supply ramp: pulse length, pins released throughout, strap taken after
	task automatic por(input logic [7:0] v);
		sup = 1'b0;
		tick(1);
		sup = 1'b1;
		n = 0;
		repeat (5) begin
			tick(1);
			if (dev_reset === 1'b1) begin
				n++;
				chk("por_oe", 16'h0000, {8'h00, pins_oe});
			end
		end
		chk("por_len", 16'(ssc_pkg::POR_CYC), 16'(n));
		chk("por_strap", {8'h00, v}, {8'h00, sw});
	endtask : por

	// Main sequence
	initial begin
		tick(16);
		srst_i = 1'b0;
		tick(2);
		por(8'h00);
		irq_ev = 8'hFF;
		tick(1);
		chk("irq_oe", 16'h0000, {15'h0000, irq_oe});
		chk("wdog", 16'h0000, {15'h0000, wdog});
		rd(16'h0202, 8'h00);
		foreach (PAT[i]) rst(PAT[i]);
		strap = 8'h5A;
		tick(3);
		chk("strap_hold", 16'h0081, {8'h00, sw});
		rd(16'h0D01, 8'h81);
		wr(16'h0204, 8'h01);
		chk("wdog_pend", 16'h0000, {15'h0000, wdog});
		rd(16'h0204, 8'h01);
		wr(16'h0202, 8'h01);
		wr(16'h0005, 8'h01);
		chk("wdog_upd", 16'h0001, {15'h0000, wdog});
		chk("od_oe", 16'h0001, {15'h0000, irq_oe});
		chk("od_pin", 16'h0000, {15'h0000, irq_pin});
		wr(16'h0203, 8'h01);
		wr(16'h0005, 8'h01);
		irq_ev = 8'h00;
		tick(1);
		chk("pp_idle", 16'h0001, {15'h0000, irq_pin});
		chk("pp_oe", 16'h0001, {15'h0000, irq_oe});
		wr(16'h0A02, 8'h01);
		wr(16'h0005, 8'h01);
		chk("cal_on", 16'h0001, {15'h0000, cal});
		wr(16'h0A02, 8'h02);
		wr(16'h0005, 8'h01);
		chk("cal_off", 16'h0000, {15'h0000, cal});
		wr(16'h0A02, 8'h00);
		wr(16'h0005, 8'h01);
		tick(2);
		chk("sync_cnt", 16'h0001, 16'(syncs));
		wr(16'h0100, 8'h34);
		wr(16'h0101, 8'h12);
		wr(16'h0300, 8'hC3);
		wr(16'h0400, 8'hFF);
		rd(16'h0400, 8'h00);
		chk("system_clock_input_hold", 16'h0000, system_clock_input_cfg);
		wr(16'h0005, 8'h01);
		chk("system_clock_input", 16'h1234, system_clock_input_cfg);
		chk("loop", 16'h00C3, {8'h00, loop_ctl});
		wr(16'h0204, 8'h00);
		ee_done = 1'b1;
		tick(1);
		ee_done = 1'b0;
		tick(2);
		chk("ee_commit", 16'h0000, {15'h0000, wdog});
		wr(16'h0200, 8'hFF);
		wr(16'h0201, 8'hA5);
		wr(16'h0005, 8'h01);
		chk("pin_oe", 16'h00FF, {8'h00, pins_oe});
		chk("pin_out", 16'h00A5, {8'h00, pins_o});
		strap = 8'h3C;
		tick(1);
		chk("strap_keep", 16'h0081, {8'h00, sw});
		por(8'h3C);
		end_sim();
	end
endmodule : ssc_startup_tb
